// ### hw/asr_regs.svh
/*
  Timing counts and field positions for the asynchronous static memory host controller.
  Assumes a 125 MHz system clock (8 ns period); all figures in ns are converted to cycles here.
*/
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH

`define ASR_CLK_PERIOD_NS   8
// Address set-up before write start, minimum (ns)
`define ASR_T_ADDR_SETUP_NS 8
// Write strobe low time, minimum (ns)
`define ASR_T_WRITE_PULSE_NS 12
// Recovery after write end before address or data change, minimum (ns)
`define ASR_T_WRITE_RECOV_NS 8
// Read access time from strobes, minimum wait (ns)
`define ASR_T_READ_ACCESS_NS 12
// Bus turnaround after the device releases the lines (ns)
`define ASR_T_TURN_NS        8

`define ASR_CYC_UP(ns) ((((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1 ? 1 : \
                        (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))
`define ASR_SETUP_CYC  `ASR_CYC_UP(`ASR_T_ADDR_SETUP_NS)
`define ASR_WPULSE_CYC `ASR_CYC_UP(`ASR_T_WRITE_PULSE_NS)
`define ASR_RECOV_CYC  `ASR_CYC_UP(`ASR_T_WRITE_RECOV_NS)
`define ASR_READ_CYC   `ASR_CYC_UP(`ASR_T_READ_ACCESS_NS)
`define ASR_TURN_CYC   `ASR_CYC_UP(`ASR_T_TURN_NS)

// Byte lane positions in a word
`define ASR_LOW_LSB  0
`define ASR_HIGH_LSB 8

`endif

// ### hw/asr_pkg.sv
/*
  Types for the asynchronous static memory host controller.
  Assumes the constants header is included by the design file.
*/
`default_nettype none
package asr_pkg;
  typedef enum logic [2:0] {
    ASR_IDLE,
    ASR_WR_SETUP,
    ASR_WR_PULSE,
    ASR_WR_RECOV,
    ASR_RD_WAIT,
    ASR_RD_DONE,
    ASR_TURN
  } asr_state_t;
endpackage
`default_nettype wire

// ### hw/asr_host.sv
/*
  Host controller that sequences strobes for a 64K x 16 asynchronous static memory with byte lanes.
  Assumes one 125 MHz clock, a synchronous active-high reset, and a user side that holds its request
  until accepted. The shared data wire is resolved outside from data_oe_out.
*/
// Notes on behaviour
// - Write starts at later of select or strobe falling; address stable before.
// - Write ends at earlier of select or strobe rising; address and data held.
// - Host keeps write strobe high throughout every read access.
// - Host never drives data lines while strobes are at read levels.
`include "asr_regs.svh"
`default_nettype none
module asr_host #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  input  wire logic [1:0]        req_lanes_in,
  output logic                   req_ready_out,
  output logic                   rsp_valid_out,
  output logic [DATA_W-1:0]      rsp_rdata_out,
  output logic [ADDR_W-1:0]      word_address_out,
  output logic                   chip_select_n_out,
  output logic                   write_strobe_n_out,
  output logic                   output_drive_enable_n_out,
  output logic                   low_byte_select_n_out,
  output logic                   high_byte_select_n_out,
  input  wire logic [DATA_W-1:0] shared_data_lines_in,
  output logic [DATA_W-1:0]      shared_data_lines_out,
  output logic                   data_oe_out
);

  localparam int SETUP_CYC  = `ASR_SETUP_CYC;
  localparam int WPULSE_CYC = `ASR_WPULSE_CYC;
  localparam int RECOV_CYC  = `ASR_RECOV_CYC;
  localparam int READ_CYC   = `ASR_READ_CYC;
  localparam int TURN_CYC   = `ASR_TURN_CYC;

  // The memory has a 16-bit word address and two 8-bit lanes; refuse other widths at elaboration
  if (ADDR_W != 16 || DATA_W != 16) begin : g_bad_width
    $error("asr_host serves only a 16-bit address and 16-bit data");
  end

  asr_pkg::asr_state_t state_reg;
  asr_pkg::asr_state_t state_next;
  logic [3:0]          count_reg;
  logic [3:0]          count_next;
  logic [ADDR_W-1:0]   addr_reg;
  logic [DATA_W-1:0]   wdata_reg;
  logic [1:0]          lanes_reg;
  logic [DATA_W-1:0]   samp1_reg;
  logic [DATA_W-1:0]   samp2_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic                rsp_reg;

  // Decode of the state into pin levels
  wire in_idle    = (state_reg == asr_pkg::ASR_IDLE);
  wire in_wsetup  = (state_reg == asr_pkg::ASR_WR_SETUP);
  wire in_wpulse  = (state_reg == asr_pkg::ASR_WR_PULSE);
  wire in_wrecov  = (state_reg == asr_pkg::ASR_WR_RECOV);
  wire in_read    = (state_reg == asr_pkg::ASR_RD_WAIT) || (state_reg == asr_pkg::ASR_RD_DONE);
  wire in_write   = in_wsetup || in_wpulse || in_wrecov;
  wire count_done = (count_reg == 4'h0);
  wire accept     = in_idle && req_valid_in && (req_lanes_in != 2'h0);

  // Select is low through the whole write so the strobe alone opens and closes the interval;
  // select falls with the address, before the strobe, so drivers stay released
  assign chip_select_n_out         = !(in_write || in_read);
  assign write_strobe_n_out        = !in_wpulse;              // High during reads
  assign output_drive_enable_n_out = !in_read;                // High in writes and idle
  assign low_byte_select_n_out     = !((in_write || in_read) && lanes_reg[0]);
  assign high_byte_select_n_out    = !((in_write || in_read) && lanes_reg[1]);
  assign word_address_out          = addr_reg;                // Held over set-up and recovery
  assign shared_data_lines_out     = wdata_reg;
  // Drive only in write phases; output enable is high then, so no contention
  assign data_oe_out               = in_write;
  assign req_ready_out             = in_idle;
  assign rsp_valid_out             = rsp_reg;
  assign rsp_rdata_out             = rdata_reg;

  // Next state and phase counter
  always_comb begin
    state_next = state_reg;
    count_next = count_done ? 4'h0 : count_reg - 4'h1;
    case (state_reg)
      asr_pkg::ASR_IDLE: begin
        if (accept) begin
          state_next = req_write_in ? asr_pkg::ASR_WR_SETUP : asr_pkg::ASR_RD_WAIT;
          count_next = req_write_in ? 4'(SETUP_CYC - 1) : 4'(READ_CYC + 1);
        end
      end
      asr_pkg::ASR_WR_SETUP: begin
        if (count_done) begin
          state_next = asr_pkg::ASR_WR_PULSE;
          count_next = 4'(WPULSE_CYC - 1);
        end
      end
      asr_pkg::ASR_WR_PULSE: begin
        if (count_done) begin
          state_next = asr_pkg::ASR_WR_RECOV;
          count_next = 4'(RECOV_CYC - 1);
        end
      end
      asr_pkg::ASR_WR_RECOV: begin
        if (count_done) begin
          state_next = asr_pkg::ASR_IDLE;
        end
      end
      asr_pkg::ASR_RD_WAIT: begin
        // Two extra cycles cover the input synchroniser
        if (count_done) begin
          state_next = asr_pkg::ASR_RD_DONE;
        end
      end
      asr_pkg::ASR_RD_DONE: begin
        state_next = asr_pkg::ASR_TURN;
        count_next = 4'(TURN_CYC - 1);
      end
      asr_pkg::ASR_TURN: begin
        // Gives the device time to release the lines before a write drives them
        if (count_done) begin
          state_next = asr_pkg::ASR_IDLE;
        end
      end
      default: begin
        state_next = asr_pkg::ASR_IDLE;
        count_next = 4'h0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= asr_pkg::ASR_IDLE;
      count_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Request capture; address and data stay put until the next accept
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      addr_reg  <= 16'h0000;
      wdata_reg <= 16'h0000;
      lanes_reg <= 2'h0;
    end else if (accept) begin
      addr_reg  <= req_addr_in;
      wdata_reg <= req_wdata_in;
      lanes_reg <= req_lanes_in;
    end
  end

  // Pin input passes two flops before use
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      samp1_reg <= 16'h0000;
      samp2_reg <= 16'h0000;
    end else begin
      samp1_reg <= shared_data_lines_in;
      samp2_reg <= samp1_reg;
    end
  end

  // Read answer; undriven lanes read as zero
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rsp_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      rsp_reg <= (state_reg == asr_pkg::ASR_RD_DONE);
      if (state_reg == asr_pkg::ASR_RD_DONE) begin
        rdata_reg[`ASR_LOW_LSB+:8]  <= lanes_reg[0] ? samp2_reg[`ASR_LOW_LSB+:8] : 8'h00;
        rdata_reg[`ASR_HIGH_LSB+:8] <= lanes_reg[1] ? samp2_reg[`ASR_HIGH_LSB+:8] : 8'h00;
      end
    end
  end

  // Assertions
  default clocking asr_cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_strobe_fall;
    $fell(write_strobe_n_out);
  endsequence
  sequence s_strobe_rise;
    $rose(write_strobe_n_out);
  endsequence

  a_no_contention: assert property (data_oe_out |-> output_drive_enable_n_out)
    else $error("host drives data while device output is enabled");
  a_read_strobe_high: assert property (!output_drive_enable_n_out |-> write_strobe_n_out)
    else $error("write strobe low during read");
  a_select_before_strobe: assert property (s_strobe_fall |-> $past(!chip_select_n_out))
    else $error("select did not fall before write strobe");
  a_addr_setup_held: assert property (s_strobe_fall |-> $stable(word_address_out))
    else $error("address changed at write start");
  a_write_end_hold: assert property (s_strobe_rise |-> $stable(word_address_out)
                                      && !chip_select_n_out && data_oe_out)
    else $error("address or data not held at write end");
  a_write_lane_low: assert property (!write_strobe_n_out |->
                                      !(low_byte_select_n_out && high_byte_select_n_out))
    else $error("write without a lane selected");
  a_pulse_width: assert property (s_strobe_fall |-> !write_strobe_n_out [*2])
    else $error("write pulse too short");
  a_read_answer: assert property ($fell(output_drive_enable_n_out) |-> ##5 rsp_valid_out)
    else $error("read answer late or missing");
  a_release_idle: assert property (chip_select_n_out |->
                                    output_drive_enable_n_out && write_strobe_n_out)
    else $error("strobes active while deselected");
  // Lane pins are already released when the answer shows, so the captured lane mask is watched
  a_lane_gate: assert property (rsp_valid_out && !lanes_reg[0] |->
                                 rsp_rdata_out[7:0] == 8'h00)
    else $error("unselected low lane returned data");

endmodule
`default_nettype wire

// ### dv/asr_sram_model.sv
/*
  Behavioural 64K x 16 static memory with two byte lanes, standing in for the device.
  Assumes active-low strobes from the host; the bench resolves the shared data wire.
*/
`default_nettype none
module asr_sram_model (
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        lo_sel_n_in,
  input  wire logic        hi_sel_n_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] data_in,
  output logic [15:0]      rdata_out,
  output logic             drv_lo_out,
  output logic             drv_hi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem_reg [0:65535];
  // Write interval: later fall starts it, earlier rise ends it
  wire logic wr_act = !cs_n_in && !we_n_in && (!lo_sel_n_in || !hi_sel_n_in);
  wire logic rd_act = !cs_n_in && we_n_in && !oe_n_in;
  // Store on the closing edge, so data is taken where the host must hold it
  always @(negedge wr_act) begin
    if (!lo_sel_n_in) mem_reg[addr_in][7:0] = data_in[7:0];
    if (!hi_sel_n_in) mem_reg[addr_in][15:8] = data_in[15:8];
  end
  // Drive only selected lanes, from the address now presented
  assign rdata_out  = mem_reg[addr_in];
  assign drv_lo_out = rd_act && !lo_sel_n_in;
  assign drv_hi_out = rd_act && !hi_sel_n_in;
endmodule
`default_nettype wire

// ### dv/tb_top.sv
/*
  Self-checking bench for the static memory host controller.
  Assumes the memory model beside it and one 125 MHz clock.
*/
`include "asr_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in = 0, sys_rst_in = 1, req_valid = 0, req_write = 0;
  logic [15:0] req_addr = 0, req_wdata = 0, pat_reg = 16'hA5A5, addr_q = 0, dout_q = 0;
  logic [1:0]  req_lanes = 0;
  logic        ready, rsp_valid, cs_n, we_n, oe_n, lo_sel_n, hi_sel_n, data_oe, drv_lo, drv_hi, cs_q = 1;
  logic [15:0] rdata, addr, dout, mdata;
  wire logic [15:0] bus;
  int          n_mismatch = 0, n_compared = 0;
  initial forever #4 clock_in = ~clock_in;
  // Released lines toggle every cycle so a stale level never passes
  always @(posedge clock_in) pat_reg <= ~pat_reg;
  assign bus[7:0]  = data_oe ? dout[7:0] : drv_lo ? mdata[7:0] : pat_reg[7:0];
  assign bus[15:8] = data_oe ? dout[15:8] : drv_hi ? mdata[15:8] : pat_reg[15:8];
  asr_host dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid),
    .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_lanes_in(req_lanes), .req_ready_out(ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rdata), .word_address_out(addr), .chip_select_n_out(cs_n),
    .write_strobe_n_out(we_n), .output_drive_enable_n_out(oe_n), .low_byte_select_n_out(lo_sel_n),
    .high_byte_select_n_out(hi_sel_n), .shared_data_lines_in(bus), .shared_data_lines_out(dout),
    .data_oe_out(data_oe));
  asr_sram_model mem_u (.cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .lo_sel_n_in(lo_sel_n),
    .hi_sel_n_in(hi_sel_n), .addr_in(addr), .data_in(bus), .rdata_out(mdata), .drv_lo_out(drv_lo),
    .drv_hi_out(drv_hi));
  task automatic check(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait on ready (rd=0) or the read answer (rd=1)
  task automatic wait_sig(input logic rd, output int n);
    for (n = 0; n < 20 && (rd ? rsp_valid : ready) !== 1'b1; n++) @(negedge clock_in);
    if (n == 20) begin
      // A used-up bound is a mismatch and goes straight to the verdict
      check("wait bound", 16'h0001, 16'h0000);
      finish_test;
    end
  endtask
  task automatic send(input logic wr, input logic [15:0] a, d, input logic [1:0] ln);
    int n;
    @(posedge clock_in);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    req_lanes <= ln;
    @(negedge clock_in);
    wait_sig(1'b0, n);
    @(posedge clock_in);
    req_valid <= 1'b0;
  endtask
  // Busy time of a write is set-up plus strobe plus recovery
  task automatic do_write(input logic [15:0] a, d, input logic [1:0] ln);
    int n;
    send(1'b1, a, d, ln);
    @(negedge clock_in);
    check("write address", a, addr);
    check("write data out", d, dout);
    check("write lanes", {14'h0000, ~ln}, {14'h0000, hi_sel_n, lo_sel_n});
    wait_sig(1'b0, n);
    check("write busy", 16'(`ASR_SETUP_CYC + `ASR_WPULSE_CYC + `ASR_RECOV_CYC), n[15:0]);
  endtask
  task automatic do_read(input logic [15:0] a, input logic [1:0] ln, input logic [15:0] exp);
    int n;
    send(1'b0, a, 16'h0000, ln);
    @(negedge clock_in);
    check("read address", a, addr);
    check("read enable", 16'h0000, {15'h0000, oe_n});
    check("read lanes", {14'h0000, ~ln}, {14'h0000, hi_sel_n, lo_sel_n});
    wait_sig(1'b1, n);
    check("read latency", 16'h0005, n[15:0]);
    check("read data", exp, rdata);
    wait_sig(1'b0, n);
  endtask
  // Pin relations watched on every cycle
  always @(negedge clock_in) if (!sys_rst_in) begin
    check("strobe in read", 16'h0000, {15'h0000, !oe_n && !we_n});
    check("contention", 16'h0000, {15'h0000, data_oe && (drv_lo || drv_hi)});
    if (!cs_n && !we_n && !cs_q) check("write addr", addr_q, addr);
    if (!cs_n && !we_n && !cs_q) check("write data", dout_q, dout);
    cs_q   = cs_n;
    addr_q = addr;
    dout_q = dout;
  end
  task automatic t_words;
    do_write(16'h0000, 16'h1234, 2'h3);
    do_write(16'hFFFF, 16'hA55A, 2'h3);
    do_read(16'h0000, 2'h3, 16'h1234);
    do_read(16'hFFFF, 2'h3, 16'hA55A);
    $display("test words done");
  endtask
  task automatic t_lanes;
    do_write(16'h0000, 16'h00CD, 2'h1);
    do_read(16'h0000, 2'h3, 16'h12CD);
    do_write(16'h0000, 16'hEF00, 2'h2);
    do_read(16'h0000, 2'h2, 16'hEF00);
    do_read(16'h0000, 2'h1, 16'h00CD);
    $display("test lanes done");
  endtask
  task automatic t_nolane;
    @(posedge clock_in);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr  <= 16'hFFFF;
    req_lanes <= 2'h0;
    repeat (4) @(negedge clock_in);
    check("idle select", 16'h0003, {14'h0000, ready, cs_n});
    @(posedge clock_in);
    req_valid <= 1'b0;
    do_read(16'hFFFF, 2'h3, 16'hA55A);
    $display("test nolane done");
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(negedge clock_in);
    check("reset idle", 16'h0012, {11'h000, ready, 2'h0, cs_n, data_oe});
    t_words;
    t_lanes;
    t_nolane;
    finish_test;
  end
endmodule
`default_nettype wire
